// [src/hbs_params.svh]
// constants of the holding brake sequencer: offsets, fields, resets, timing
//
// Notes on behaviour
// - on switch-on, magnetize for the set time, then command the brake open
// - after opening, hold zero speed for the opening time, then ramp
// - ramp or quick stop decelerates; setpoint, speed compared to threshold
// - setpoint under threshold in a stop starts the standstill monitor timer
// - speed under threshold in a stop starts the pulse removal delay timer
// - first stop timer to expire closes the brake; motor stays energized
// - after the closing time, drive pulses are removed
// - coast stop closes brake at once, any speed, no closing time
// - mode 0 off, 1 sequence, 2 always open, 3 sequence on routed output
// - opening time resets to 0.1 s; set above relay plus release time
// - closing time resets to 0.1 s; set above relay plus closing time
// - magnetizing time resets to 0 s; motor is magnetized before release
// - forced open and forced close controls, both reset inactive
// - standstill speed threshold resets to 20 rpm
// - standstill monitor time resets to 300 s
// - pulse removal delay resets to 0.01 s
// - start frequency above zero turns slip compensation on; resets to 0%
`ifndef HBS_PARAMS_SVH
`define HBS_PARAMS_SVH

// ********************************************************************
// register byte offsets
// ********************************************************************
`define HBS_ADDR_MODE     8'h00
`define HBS_ADDR_OPEN     8'h04
`define HBS_ADDR_CLOSE    8'h08
`define HBS_ADDR_MAG      8'h0c
`define HBS_ADDR_THRESH   8'h10
`define HBS_ADDR_MONITOR  8'h14
`define HBS_ADDR_PULSE    8'h18
`define HBS_ADDR_FORCE    8'h1c
`define HBS_ADDR_STARTF   8'h20
`define HBS_ADDR_STATUS   8'h24

// ********************************************************************
// field positions
// ********************************************************************
`define HBS_FORCE_OPEN_BIT   0
`define HBS_FORCE_CLOSE_BIT  1
`define HBS_ST_BRAKE_BIT     3
`define HBS_ST_PULSE_BIT     4
`define HBS_ST_RAMP_BIT      5
`define HBS_ST_MAG_BIT       6
`define HBS_ST_DECEL_BIT     7
`define HBS_ST_MONRUN_BIT    8
`define HBS_ST_DLYRUN_BIT    9
`define HBS_ST_SLIP_BIT      10

// ********************************************************************
// reset values, times in milliseconds, speed in rpm
// ********************************************************************
`define HBS_RST_MODE      2'h0
`define HBS_RST_OPEN      20'h00064
`define HBS_RST_CLOSE     20'h00064
`define HBS_RST_MAG       20'h00000
`define HBS_RST_THRESH    16'h0014
`define HBS_RST_MONITOR   20'h493e0
`define HBS_RST_PULSE     20'h0000a
`define HBS_RST_STARTF    8'h00

// ********************************************************************
// timing
// ********************************************************************
`define HBS_CLK_PERIOD_NS   100
`define HBS_TICK_PERIOD_NS  1000000
`define HBS_TICK_CYCLES \
  (`HBS_TICK_PERIOD_NS / `HBS_CLK_PERIOD_NS)

`endif

// [src/hbs_pkg.sv]
// types of the holding brake sequencer
package hbs_pkg;

  // ********************************************************************
  // sequence states
  // ********************************************************************
  typedef enum logic [2:0] {
    HBS_OFF,
    HBS_MAGNETIZE,
    HBS_OPENING,
    HBS_RUN,
    HBS_STOPPING,
    HBS_CLOSING
  } hbs_state_t;

  // ********************************************************************
  // software settings, times in ms
  // ********************************************************************
  typedef struct packed {
    logic [1:0]  mode;
    logic [19:0] openMs;
    logic [19:0] closeMs;
    logic [19:0] magMs;
    logic [15:0] thresh;
    logic [19:0] monitorMs;
    logic [19:0] pulseMs;
    logic        forceOpen;
    logic        forceClose;
    logic [7:0]  startFreq;
  } hbs_cfg_t;

endpackage : hbs_pkg

// [src/hbs_timer.sv]
// millisecond timer with restart and clear, expiry as a level
`timescale 1ns/1ns
`default_nettype none
module hbs_timer #(
  parameter int W = 20
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic         start,
  input  wire logic         clear,
  input  wire logic         tick,
  input  wire logic [W-1:0] limit,
  output logic              running,
  output logic              done
);

  logic [W-1:0] cnt_q;
  logic         run_q;

  // expiry as soon as the count reaches the limit; zero expires at once
  assign running = run_q;
  assign done    = run_q && (cnt_q >= limit);

  // start restarts from zero; counting stops at the limit
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end
    else if (clear)
    begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end
    else if (start)
    begin
      cnt_q <= '0;
      run_q <= 1'b1;
    end
    else if (run_q && tick && (cnt_q < limit))
    begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

endmodule : hbs_timer
`default_nettype wire

// [src/hbs_brake_seq.sv]
// holding brake sequencer: state machine, timers, registers
`timescale 1ns/1ns
`default_nettype none
`include "hbs_params.svh"
module hbs_brake_seq #(
  parameter int TICK_CYCLES = `HBS_TICK_CYCLES
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic [31:0]      regRdata,
  input  wire logic        switchOn,
  input  wire logic        quickStop,
  input  wire logic        coastStop,
  input  wire logic [15:0] speedSetpoint,
  input  wire logic [15:0] speedActual,
  output logic             brakeOpen,
  output logic             brakeOpenRouted,
  output logic             pulseEnable,
  output logic             magnetizing,
  output logic             rampEnable,
  output logic             decelerating,
  output logic             slipCompEnable
);

  // ********************************************************************
  // declarations
  // ********************************************************************
  hbs_pkg::hbs_cfg_t   cfg_q;
  hbs_pkg::hbs_state_t state_q;
  hbs_pkg::hbs_state_t state_d;
  logic [31:0]         rdata_q;
  logic [31:0]         tickCnt_q;
  logic                tick_q;
  logic                brake_q;
  logic                brakeRt_q;
  logic                pulse_q;
  logic                mag_q;
  logic                ramp_q;
  logic                decel_q;
  logic                slip_q;
  logic                brakeCmd;
  logic                seqBrake;
  logic                stopReq;
  logic                brakeUsed;
  logic                spBelow;
  logic                actBelow;
  logic                inStop;
  logic                phaseStart;
  logic [19:0]         phaseLimit;
  logic                phaseDone;
  logic                monRun;
  logic                monDone;
  logic                dlyRun;
  logic                dlyDone;
  logic                stopDone;
  logic [31:0]         statusWord;
  logic [31:0]         readMux;

  // speed magnitude strictly under the standstill threshold
  function automatic logic below(input logic [15:0] spd,
                                 input logic [15:0] thr);
    below = spd < thr;
  endfunction : below

  // ********************************************************************
  // register writes
  // ********************************************************************
  // reset values give a disabled brake and inactive forcing
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cfg_q.mode       <= `HBS_RST_MODE;
      cfg_q.openMs     <= `HBS_RST_OPEN;
      cfg_q.closeMs    <= `HBS_RST_CLOSE;
      cfg_q.magMs      <= `HBS_RST_MAG;
      cfg_q.thresh     <= `HBS_RST_THRESH;
      cfg_q.monitorMs  <= `HBS_RST_MONITOR;
      cfg_q.pulseMs    <= `HBS_RST_PULSE;
      cfg_q.forceOpen  <= 1'b0;
      cfg_q.forceClose <= 1'b0;
      cfg_q.startFreq  <= `HBS_RST_STARTF;
    end
    else if (regWr)
    begin
      unique case (regAddr)
        `HBS_ADDR_MODE:    cfg_q.mode      <= regWdata[1:0];
        `HBS_ADDR_OPEN:    cfg_q.openMs    <= regWdata[19:0];
        `HBS_ADDR_CLOSE:   cfg_q.closeMs   <= regWdata[19:0];
        `HBS_ADDR_MAG:     cfg_q.magMs     <= regWdata[19:0];
        `HBS_ADDR_THRESH:  cfg_q.thresh    <= regWdata[15:0];
        `HBS_ADDR_MONITOR: cfg_q.monitorMs <= regWdata[19:0];
        `HBS_ADDR_PULSE:   cfg_q.pulseMs   <= regWdata[19:0];
        `HBS_ADDR_FORCE:
        begin
          cfg_q.forceOpen  <= regWdata[`HBS_FORCE_OPEN_BIT];
          cfg_q.forceClose <= regWdata[`HBS_FORCE_CLOSE_BIT];
        end
        `HBS_ADDR_STARTF:  cfg_q.startFreq <= regWdata[7:0];
        default:           cfg_q           <= cfg_q;
      endcase
    end
  end

  // ********************************************************************
  // register reads
  // ********************************************************************
  // status shows live sequence state; unmapped offsets read zero
  assign statusWord = {21'h0, slip_q, dlyRun, monRun, decel_q, mag_q,
                       ramp_q, pulse_q, brakeCmd, state_q};
  assign readMux =
    (regAddr == `HBS_ADDR_MODE)    ? {30'h0, cfg_q.mode}      :
    (regAddr == `HBS_ADDR_OPEN)    ? {12'h0, cfg_q.openMs}    :
    (regAddr == `HBS_ADDR_CLOSE)   ? {12'h0, cfg_q.closeMs}   :
    (regAddr == `HBS_ADDR_MAG)     ? {12'h0, cfg_q.magMs}     :
    (regAddr == `HBS_ADDR_THRESH)  ? {16'h0, cfg_q.thresh}    :
    (regAddr == `HBS_ADDR_MONITOR) ? {12'h0, cfg_q.monitorMs} :
    (regAddr == `HBS_ADDR_PULSE)   ? {12'h0, cfg_q.pulseMs}   :
    (regAddr == `HBS_ADDR_FORCE)   ? {30'h0, cfg_q.forceClose,
                                      cfg_q.forceOpen}        :
    (regAddr == `HBS_ADDR_STARTF)  ? {24'h0, cfg_q.startFreq} :
    (regAddr == `HBS_ADDR_STATUS)  ? statusWord               :
                                     32'h0;

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      rdata_q <= 32'h0;
    else
      rdata_q <= regRd ? readMux : 32'h0;
  end

  // ********************************************************************
  // millisecond tick
  // ********************************************************************
  // one shared tick keeps all timers in step and their counters narrow
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      tickCnt_q <= 32'h0;
      tick_q    <= 1'b0;
    end
    else
    begin
      tick_q    <= (tickCnt_q == 32'(TICK_CYCLES - 1));
      tickCnt_q <= (tickCnt_q == 32'(TICK_CYCLES - 1)) ? 32'h0
                                                       : tickCnt_q + 32'h1;
    end
  end

  // ********************************************************************
  // sequence decisions
  // ********************************************************************
  assign stopReq   = !switchOn || quickStop;
  assign brakeUsed = (cfg_q.mode == 2'h1) || (cfg_q.mode == 2'h3);
  assign spBelow   = below(speedSetpoint, cfg_q.thresh);
  assign actBelow  = below(speedActual, cfg_q.thresh);
  assign inStop    = (state_q == hbs_pkg::HBS_STOPPING);
  assign stopDone  = monDone || dlyDone;

  // next state; coast stop wins from every state
  always_comb
  begin
    state_d = state_q;
    if (coastStop)
      state_d = hbs_pkg::HBS_OFF;
    else
    begin
      unique case (state_q)
        hbs_pkg::HBS_OFF:
          if (!stopReq)
            state_d = hbs_pkg::HBS_MAGNETIZE;
        hbs_pkg::HBS_MAGNETIZE:
          if (stopReq)
            state_d = hbs_pkg::HBS_OFF;
          else if (phaseDone)
            state_d = brakeUsed ? hbs_pkg::HBS_OPENING
                                : hbs_pkg::HBS_RUN;
        hbs_pkg::HBS_OPENING:
          if (stopReq)
            state_d = hbs_pkg::HBS_STOPPING;
          else if (phaseDone)
            state_d = hbs_pkg::HBS_RUN;
        hbs_pkg::HBS_RUN:
          if (stopReq)
            state_d = hbs_pkg::HBS_STOPPING;
        hbs_pkg::HBS_STOPPING:
          if (stopDone)
            state_d = brakeUsed ? hbs_pkg::HBS_CLOSING
                                : hbs_pkg::HBS_OFF;
        hbs_pkg::HBS_CLOSING:
          if (phaseDone)
            state_d = hbs_pkg::HBS_OFF;
        default:
          state_d = hbs_pkg::HBS_OFF;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      state_q <= hbs_pkg::HBS_OFF;
    else
      state_q <= state_d;
  end

  // ********************************************************************
  // timers
  // ********************************************************************
  // one phase timer serves magnetize, opening and closing in turn
  assign phaseStart = (state_d != state_q) &&
                      ((state_d == hbs_pkg::HBS_MAGNETIZE) ||
                       (state_d == hbs_pkg::HBS_OPENING) ||
                       (state_d == hbs_pkg::HBS_CLOSING));
  assign phaseLimit =
    (state_q == hbs_pkg::HBS_MAGNETIZE) ? cfg_q.magMs   :
    (state_q == hbs_pkg::HBS_OPENING)   ? cfg_q.openMs  :
                                          cfg_q.closeMs;

  hbs_timer #(.W(20)) phaseTimer (
    .clk_sys (clk_sys),
    .rst     (rst),
    .start   (phaseStart),
    .clear   (1'b0),
    .tick    (tick_q),
    .limit   (phaseLimit),
    .running (),
    .done    (phaseDone)
  );

  // stop timers start once per stop and are cleared outside it
  hbs_timer #(.W(20)) monTimer (
    .clk_sys (clk_sys),
    .rst     (rst),
    .start   (inStop && spBelow && !monRun),
    .clear   (!inStop),
    .tick    (tick_q),
    .limit   (cfg_q.monitorMs),
    .running (monRun),
    .done    (monDone)
  );

  hbs_timer #(.W(20)) dlyTimer (
    .clk_sys (clk_sys),
    .rst     (rst),
    .start   (inStop && actBelow && !dlyRun),
    .clear   (!inStop),
    .tick    (tick_q),
    .limit   (cfg_q.pulseMs),
    .running (dlyRun),
    .done    (dlyDone)
  );

  // ********************************************************************
  // outputs
  // ********************************************************************
  // brake held open from opening through the stop until a timer expires
  assign seqBrake = (state_d == hbs_pkg::HBS_OPENING) ||
                    (state_d == hbs_pkg::HBS_RUN) ||
                    (state_d == hbs_pkg::HBS_STOPPING);
  // coast and forced close override everything, including forced open
  assign brakeCmd = !coastStop && !cfg_q.forceClose &&
                    (cfg_q.forceOpen ||
                     (cfg_q.mode == 2'h2) ||
                     (brakeUsed && seqBrake));

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      brake_q   <= 1'b0;
      brakeRt_q <= 1'b0;
      pulse_q   <= 1'b0;
      mag_q     <= 1'b0;
      ramp_q    <= 1'b0;
      decel_q   <= 1'b0;
      slip_q    <= 1'b0;
    end
    else
    begin
      brake_q   <= brakeCmd && (cfg_q.mode != 2'h3);
      brakeRt_q <= brakeCmd && (cfg_q.mode == 2'h3);
      pulse_q   <= (state_d != hbs_pkg::HBS_OFF);
      mag_q     <= (state_d == hbs_pkg::HBS_MAGNETIZE);
      ramp_q    <= (state_d == hbs_pkg::HBS_RUN);
      decel_q   <= (state_d == hbs_pkg::HBS_STOPPING);
      slip_q    <= (cfg_q.startFreq != 8'h00);
    end
  end

  assign regRdata        = rdata_q;
  assign brakeOpen       = brake_q;
  assign brakeOpenRouted = brakeRt_q;
  assign pulseEnable     = pulse_q;
  assign magnetizing     = mag_q;
  assign rampEnable      = ramp_q;
  assign decelerating    = decel_q;
  assign slipCompEnable  = slip_q;

  // ********************************************************************
  // assertions
  // ********************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence magEndS;
    state_q == hbs_pkg::HBS_MAGNETIZE && phaseDone && !coastStop &&
    switchOn && !quickStop && cfg_q.mode == 2'h1 && !cfg_q.forceClose;
  endsequence
  sequence stopEndS;
    inStop && stopDone && !coastStop && cfg_q.mode == 2'h1;
  endsequence

  mag_then_open_a: assert property (
    magEndS |=> state_q == hbs_pkg::HBS_OPENING && brakeOpen)
    else $error("brake not opened after magnetizing");
  hold_zero_a: assert property (
    $rose(rampEnable) && $past(brakeUsed) |->
    $past(state_q) == hbs_pkg::HBS_OPENING && $past(phaseDone))
    else $error("ramp started before brake opening time");
  mon_start_a: assert property (
    inStop && spBelow && !monRun && !stopDone && !coastStop |=> monRun)
    else $error("monitor timer not started");
  dly_start_a: assert property (
    inStop && actBelow && !dlyRun && !stopDone && !coastStop |=> dlyRun)
    else $error("pulse delay timer not started");
  stop_close_a: assert property (
    stopEndS ##0 !cfg_q.forceOpen |=> !brakeOpen && pulseEnable)
    else $error("brake not closed on stop timer expiry");
  close_off_a: assert property (
    state_q == hbs_pkg::HBS_CLOSING && phaseDone && !coastStop
    |=> !pulseEnable ##1 state_q == hbs_pkg::HBS_MAGNETIZE || !pulseEnable)
    else $error("pulses not removed after closing time");
  coast_close_a: assert property (
    coastStop |=> !brakeOpen && !brakeOpenRouted && !pulseEnable)
    else $error("coast stop did not close brake");
  mode_off_a: assert property (
    cfg_q.mode == 2'h0 && !cfg_q.forceOpen |=> !brakeOpen)
    else $error("brake opened while disabled");
  force_close_a: assert property (
    cfg_q.forceClose |=> !brakeOpen && !brakeOpenRouted)
    else $error("forced close did not win");
  slip_on_a: assert property (
    cfg_q.startFreq != 8'h00 |=> slipCompEnable)
    else $error("slip compensation not enabled");

endmodule : hbs_brake_seq
`default_nettype wire

// [verif/hbs_brake_model.sv]
// brake actuator model behind the relay output
`timescale 1ns/1ns
`default_nettype none
module hbs_brake_model #(
  parameter int DLY = 12
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic cmdOpen,
  output logic      released
);
  // ********************************************************************
  // relay plus mechanical delay
  // ********************************************************************
  int cnt;

  // the brake moves only once the command has stood still for DLY cycles,
  // so a sequencer that hurries past its times is caught at the shaft
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cnt      <= 0;
      released <= 1'b0;
    end
    else if (cmdOpen == released)
      cnt <= 0;
    else if (cnt == DLY - 1)
    begin
      cnt      <= 0;
      released <= cmdOpen;
    end
    else
      cnt <= cnt + 1;
  end
endmodule : hbs_brake_model
`default_nettype wire

// [verif/tb.sv]
// self-checking bench of the holding brake sequencer
`timescale 1ns/1ns
`default_nettype none
module tb;
  // ********************************************************************
  // stimulus, design and brake
  // ********************************************************************
  localparam int T = 4;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic        switchOn = 1'b0;
  logic        quickStop = 1'b0;
  logic        coastStop = 1'b0;
  logic [15:0] speedSetpoint = 16'h0064;
  logic [15:0] speedActual = 16'h0064;
  logic [31:0] regRdata;
  logic [31:0] rdv;
  logic        brakeOpen, brakeOpenRouted, pulseEnable, magnetizing;
  logic        rampEnable, decelerating, slipCompEnable, released;
  wire  [6:0]  outs;
  int          n, nFail, samplesChecked, cyc;
  logic [7:0]  ra [10] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10,
                           8'h14, 8'h18, 8'h1c, 8'h20, 8'h28};
  logic [31:0] rv [10] = '{32'h0, 32'h64, 32'h64, 32'h0, 32'h14,
                           32'h493e0, 32'ha, 32'h0, 32'h0, 32'h0};

  // outputs gathered so one wait task serves them all
  assign outs = {slipCompEnable, decelerating, rampEnable, magnetizing,
                 pulseEnable, brakeOpenRouted, brakeOpen};

  hbs_brake_seq #(.TICK_CYCLES(T)) dut_u (
    .clk_sys(clk_sys), .rst(rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .switchOn(switchOn), .quickStop(quickStop),
    .coastStop(coastStop), .speedSetpoint(speedSetpoint),
    .speedActual(speedActual), .brakeOpen(brakeOpen),
    .brakeOpenRouted(brakeOpenRouted), .pulseEnable(pulseEnable),
    .magnetizing(magnetizing), .rampEnable(rampEnable),
    .decelerating(decelerating), .slipCompEnable(slipCompEnable));

  hbs_brake_model #(.DLY(12)) brake_u (
    .clk_sys(clk_sys), .rst(rst),
    .cmdOpen(brakeOpen | brakeOpenRouted), .released(released));

  // ********************************************************************
  // tasks
  // ********************************************************************
  task automatic tally_and_finish();
    if (nFail == 0 && samplesChecked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samplesChecked++;
    if (g !== e)
    begin
      nFail++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask : chk

  task automatic rng(input int v, input int lo, input int hi);
    samplesChecked++;
    if (v < lo || v > hi)
    begin
      nFail++;
      $display("[ERR] %0t got %h want %h..%h", $time, v, lo, hi);
    end
  endtask : rng

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clk_sys);
    regWr    <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk_sys);
    regRd   <= 1'b0;
    @(negedge clk_sys);
    d = regRdata;
  endtask : rd

  // bounded wait; a hang shows up as a count out of range
  task automatic waitb(input int b, input logic v, output int c);
    c = 0;
    while (outs[b] !== v && c < 3000)
    begin
      @(posedge clk_sys);
      #1;
      c++;
    end
  endtask : waitb

  task automatic runup(input int b);
    @(posedge clk_sys);
    switchOn      <= 1'b1;
    quickStop     <= 1'b0;
    speedSetpoint <= 16'h0064;
    speedActual   <= 16'h0064;
    waitb(3, 1'b1, n);
    rng(n, 1, 2);
    waitb(b, 1'b1, n);
    rng(n, 2 * T + 2, 3 * T + 1);
    chk(32'(rampEnable), 32'h0);
    waitb(4, 1'b1, n);
    rng(n, 4 * T + 2, 5 * T + 1);
    chk(32'(released), 32'h1);
  endtask : runup

  // q high: quick stop with run held; q low: ramp stop
  task automatic stopc(input int b, input logic q, input logic [15:0] sp,
                       input logic [15:0] a, input int lo, input int hi);
    @(posedge clk_sys);
    quickStop     <= q;
    switchOn      <= q;
    speedSetpoint <= sp;
    speedActual   <= a;
    waitb(5, 1'b1, n);
    rng(n, 1, 2);
    waitb(b, 1'b0, n);
    rng(n, lo, hi);
    chk(32'(pulseEnable), 32'h1);
    waitb(2, 1'b0, n);
    rng(n, 3 * T + 2, 4 * T + 1);
    chk(32'(released), 32'h0);
  endtask : stopc

  // ********************************************************************
  // clock, timeout, main sequence
  // ********************************************************************
  initial
  begin
    forever #50 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      nFail++;
      tally_and_finish();
    end
  end

  initial
  begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 10; i++)
    begin
      rd(ra[i], rdv);
      chk(rdv, rv[i]);
    end
    wr(8'h00, 32'h1);
    wr(8'h0c, 32'h3);
    wr(8'h04, 32'h5);
    wr(8'h08, 32'h4);
    wr(8'h14, 32'h5);
    wr(8'h18, 32'h8);
    rd(8'h14, rdv);
    chk(rdv, 32'h5);
    runup(0);
    rd(8'h24, rdv);
    chk(rdv & 32'h7, 32'h3);
    stopc(0, 1'b0, 16'h000a, 16'h0064, 4 * T + 3, 5 * T + 2);
    runup(0);
    stopc(0, 1'b1, 16'h0014, 16'h000a, 7 * T + 3, 8 * T + 2);
    runup(0);
    @(posedge clk_sys);
    coastStop <= 1'b1;
    waitb(0, 1'b0, n);
    rng(n, 1, 2);
    chk(32'(pulseEnable), 32'h0);
    @(posedge clk_sys);
    coastStop <= 1'b0;
    switchOn  <= 1'b0;
    wr(8'h00, 32'h2);
    waitb(0, 1'b1, n);
    rng(n, 1, 3);
    wr(8'h1c, 32'h3);
    waitb(0, 1'b0, n);
    rng(n, 0, 3);
    wr(8'h00, 32'h0);
    wr(8'h1c, 32'h1);
    waitb(0, 1'b1, n);
    rng(n, 0, 3);
    wr(8'h1c, 32'h0);
    wr(8'h00, 32'h3);
    runup(1);
    chk(32'(brakeOpen), 32'h0);
    stopc(1, 1'b0, 16'h000a, 16'h000a, 4 * T + 3, 5 * T + 2);
    wr(8'h20, 32'h5);
    waitb(6, 1'b1, n);
    rng(n, 0, 3);
    wr(8'h20, 32'h0);
    waitb(6, 1'b0, n);
    rng(n, 0, 3);
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
